// ===== core/cfsp_pkg.sv
// Package for the processor core register set: flag positions, reset values, operation codes.
package cfsp_pkg;
    localparam int CFSP_W = 8;
    localparam logic [15:0] CFSP_SP_RESET = 16'h01ff;
    localparam logic [7:0] CFSP_SP_HIGH = 8'h01;
    localparam logic [7:0] CFSP_SP_LOW_RESET = 8'hff;
    localparam int CFSP_CC_C = 0;
    localparam int CFSP_CC_Z = 1;
    localparam int CFSP_CC_N = 2;
    localparam int CFSP_CC_I0 = 3;
    localparam int CFSP_CC_H = 4;
    localparam int CFSP_CC_I1 = 5;
    localparam logic [7:0] CFSP_CC_FIXED = 8'hc0;
    localparam logic [7:0] CFSP_CC_RESET = 8'hea;
    localparam logic [1:0] CFSP_LVL0 = 2'h2;
    localparam logic [1:0] CFSP_LVL1 = 2'h1;
    localparam logic [1:0] CFSP_LVL2 = 2'h0;
    localparam logic [1:0] CFSP_LVL3 = 2'h3;
    localparam logic [2:0] CFSP_IRQ_BYTES = 3'h5;
    localparam logic [2:0] CFSP_CALL_BYTES = 3'h2;
    localparam int CFSP_MEM_DEPTH = 256;

    typedef enum logic [3:0] {
        CFSP_ALU_ADD = 4'h0,
        CFSP_ALU_ADC = 4'h1,
        CFSP_ALU_SUB = 4'h2,
        CFSP_ALU_SBC = 4'h3,
        CFSP_ALU_AND = 4'h4,
        CFSP_ALU_OR = 4'h5,
        CFSP_ALU_XOR = 4'h6,
        CFSP_ALU_LD = 4'h7,
        CFSP_ALU_SLL = 4'h8,
        CFSP_ALU_SRL = 4'h9,
        CFSP_ALU_RLC = 4'ha,
        CFSP_ALU_RRC = 4'hb
    } cfsp_alu_t;

    typedef enum logic [3:0] {
        CFSP_OP_NONE = 4'h0,
        CFSP_OP_SCF = 4'h1,
        CFSP_OP_RCF = 4'h2,
        CFSP_OP_RIM = 4'h3,
        CFSP_OP_SIM = 4'h4,
        CFSP_OP_RSP = 4'h5,
        CFSP_OP_LDS = 4'h6,
        CFSP_OP_PUSHCC = 4'h7,
        CFSP_OP_POPCC = 4'h8,
        CFSP_OP_CALL = 4'h9,
        CFSP_OP_RET = 4'ha,
        CFSP_OP_IRQ = 4'hb,
        CFSP_OP_INTERRUPT_RETURN_INSTRUCTION = 4'hc,
        CFSP_OP_HALT = 4'hd,
        CFSP_OP_WFI = 4'he,
        CFSP_OP_BTJ = 4'hf
    } cfsp_op_t;

    typedef enum logic [4:0] {
        CFSP_ST_IDLE = 5'b00001,
        CFSP_ST_PUSH = 5'b00010,
        CFSP_ST_POP = 5'b00100,
        CFSP_ST_DONE = 5'b01000,
        CFSP_ST_FETCH = 5'b10000
    } cfsp_state_t;
endpackage : cfsp_pkg

// ===== core/cfsp_stack_ram.sv
// Stack memory: 256 bytes, registered read data.
`timescale 1ns/10ps
`default_nettype none
module cfsp_stack_ram
    import cfsp_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic we, // Write strobe
    input wire logic [7:0] addr, // Byte address inside the stack page
    input wire logic [7:0] wdata, // Write data
    output logic [7:0] rdata // Registered read data
);
    logic [7:0] mem [CFSP_MEM_DEPTH];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : cfsp_stack_ram
`default_nettype wire

// ===== core/cfsp_core_regs.sv
// Processor core register set: accumulator, index registers, program counter, flags, stack.
`timescale 1ns/10ps
`default_nettype none
module cfsp_core_regs
    import cfsp_pkg::*;
(
    input wire logic mclk, // 40 MHz clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic alu_valid, // One-cycle pulse: apply an ALU result
    input wire cfsp_alu_t alu_op, // ALU operation
    input wire logic [7:0] alu_a, // First operand
    input wire logic [7:0] alu_b, // Second operand
    input wire logic [1:0] alu_dest, // 0 accumulator, 1 first index, 2 second index, 3 none
    input wire logic op_valid, // One-cycle pulse: start a special operation
    input wire cfsp_op_t op_code, // Special operation
    input wire logic [7:0] op_data, // Byte for stack-pointer load
    input wire logic [15:0] op_addr, // Target address for call or interrupt vector
    input wire logic [1:0] vec_priority, // Priority bits of the serviced vector
    input wire logic btj_bit, // Tested bit for bit-test-and-branch
    input wire logic pc_load, // Load program counter
    input wire logic pc_inc, // Advance program counter by one
    input wire logic [15:0] pc_value, // Program counter load value
    output logic [7:0] accumulator_q, // Accumulator
    output logic [7:0] index_x_q, // First index register
    output logic [7:0] index_y_q, // Second index register
    output logic [15:0] program_counter_q, // Program counter
    output logic [7:0] condition_code_flags_q, // Condition-code register
    output logic [15:0] stack_pointer_q, // Stack pointer
    output logic irq_masked_q, // Priority level 3 in force
    output logic busy_q, // Stack sequence in progress
    output logic done_q // One-cycle pulse at end of a stack sequence
);
    cfsp_state_t state_q;
    logic [7:0] flags_q;
    logic [7:0] sp_low_q;
    logic [2:0] cnt_q;
    logic [2:0] len_q;
    logic is_irq_q;
    logic [15:0] tgt_q;
    logic [7:0] ram_rdata;
    logic ram_we;
    logic [7:0] ram_wdata;
    logic [7:0] ram_addr;
    logic [8:0] sum;
    logic [4:0] half;
    logic cin;
    logic [7:0] res;
    logic cout;
    logic upd_c;
    logic upd_h;
    logic [7:0] sp_next;
    logic push_seq_q;

    // Upper stack byte is a constant, so only the low byte is stored
    // fixed upper byte
    assign stack_pointer_q = {CFSP_SP_HIGH, sp_low_q};
    assign condition_code_flags_q = flags_q | CFSP_CC_FIXED;

    // ALU result and flag computation
    always_comb begin
        cin = flags_q[CFSP_CC_C];
        sum = 9'h000;
        half = 5'h00;
        res = alu_b;
        cout = flags_q[CFSP_CC_C];
        upd_c = 1'b0;
        upd_h = 1'b0;
        case (alu_op)
            CFSP_ALU_ADD, CFSP_ALU_ADC: begin
                sum = {1'b0, alu_a} + {1'b0, alu_b}
                    + {8'h00, (alu_op == CFSP_ALU_ADC) & cin};
                half = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}
                    + {4'h0, (alu_op == CFSP_ALU_ADC) & cin};
                res = sum[7:0];
                cout = sum[8];
                upd_c = 1'b1;
                upd_h = 1'b1;
            end
            CFSP_ALU_SUB, CFSP_ALU_SBC: begin
                sum = {1'b0, alu_a} - {1'b0, alu_b}
                    - {8'h00, (alu_op == CFSP_ALU_SBC) & cin};
                res = sum[7:0];
                cout = sum[8];
                upd_c = 1'b1;
            end
            CFSP_ALU_AND: res = alu_a & alu_b;
            CFSP_ALU_OR: res = alu_a | alu_b;
            CFSP_ALU_XOR: res = alu_a ^ alu_b;
            CFSP_ALU_LD: res = alu_b;
            CFSP_ALU_SLL: begin
                res = {alu_a[6:0], 1'b0};
                cout = alu_a[7];
                upd_c = 1'b1;
            end
            CFSP_ALU_SRL: begin
                res = {1'b0, alu_a[7:1]};
                cout = alu_a[0];
                upd_c = 1'b1;
            end
            CFSP_ALU_RLC: begin
                res = {alu_a[6:0], cin};
                cout = alu_a[7];
                upd_c = 1'b1;
            end
            CFSP_ALU_RRC: begin
                res = {cin, alu_a[7:1]};
                cout = alu_a[0];
                upd_c = 1'b1;
            end
            default: res = alu_b;
        endcase
    end

    // Stack byte addressed by the sequence; pushes descend, pops ascend
    always_comb begin
        ram_we = 1'b0;
        ram_wdata = 8'h00;
        ram_addr = sp_low_q;
        sp_next = sp_low_q + 8'h01;
        if (state_q == CFSP_ST_PUSH) begin
            ram_we = 1'b1;
            case (cnt_q)
                3'h0: ram_wdata = program_counter_q[7:0];
                3'h1: ram_wdata = program_counter_q[15:8];
                3'h2: ram_wdata = is_irq_q ? index_x_q : 8'h00;
                3'h3: ram_wdata = accumulator_q;
                3'h4: ram_wdata = condition_code_flags_q;
                default: ram_wdata = 8'h00;
            endcase
            if (!is_irq_q && len_q == 3'h1) begin
                ram_wdata = condition_code_flags_q;
            end
        end else if (state_q == CFSP_ST_POP) begin
            ram_addr = sp_next;
        end
    end

    cfsp_stack_ram u_ram (
        .mclk(mclk),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    // Stack sequencer: pushes one byte a cycle, pops take a read cycle each
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= CFSP_ST_IDLE;
            cnt_q <= 3'h0;
            len_q <= 3'h0;
            is_irq_q <= 1'b0;
            tgt_q <= 16'h0000;
            push_seq_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                CFSP_ST_IDLE: begin
                    cnt_q <= 3'h0;
                    if (op_valid) begin
                        tgt_q <= op_addr;
                        is_irq_q <= op_code inside {CFSP_OP_IRQ, CFSP_OP_INTERRUPT_RETURN_INSTRUCTION};
                        push_seq_q <= op_code inside {CFSP_OP_CALL, CFSP_OP_IRQ, CFSP_OP_PUSHCC};
                        len_q <= (op_code inside {CFSP_OP_IRQ, CFSP_OP_INTERRUPT_RETURN_INSTRUCTION}) ? CFSP_IRQ_BYTES
                            : (op_code inside {CFSP_OP_CALL, CFSP_OP_RET}) ? CFSP_CALL_BYTES
                            : 3'h1;
                        case (op_code)
                            CFSP_OP_CALL, CFSP_OP_IRQ, CFSP_OP_PUSHCC: begin
                                state_q <= CFSP_ST_PUSH;
                                busy_q <= 1'b1;
                            end
                            CFSP_OP_RET, CFSP_OP_INTERRUPT_RETURN_INSTRUCTION, CFSP_OP_POPCC: begin
                                state_q <= CFSP_ST_POP;
                                busy_q <= 1'b1;
                            end
                            default: state_q <= CFSP_ST_IDLE;
                        endcase
                    end
                end
                CFSP_ST_PUSH: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q + 3'h1 == len_q) begin
                        state_q <= CFSP_ST_DONE;
                    end
                end
                CFSP_ST_POP: begin
                    state_q <= CFSP_ST_FETCH;
                end
                CFSP_ST_FETCH: begin
                    cnt_q <= cnt_q + 3'h1;
                    state_q <= (cnt_q + 3'h1 == len_q) ? CFSP_ST_DONE : CFSP_ST_POP;
                end
                CFSP_ST_DONE: begin
                    state_q <= CFSP_ST_IDLE;
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                default: state_q <= CFSP_ST_IDLE;
            endcase
        end
    end

    // Stack pointer low byte
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sp_low_q <= CFSP_SP_LOW_RESET;
        end else if (state_q == CFSP_ST_PUSH) begin
            sp_low_q <= sp_low_q - 8'h01;
        end else if (state_q == CFSP_ST_POP) begin
            sp_low_q <= sp_next;
        end else if (state_q == CFSP_ST_IDLE && op_valid) begin
            if (op_code == CFSP_OP_RSP) begin
                sp_low_q <= CFSP_SP_LOW_RESET;
            end else if (op_code == CFSP_OP_LDS) begin
                sp_low_q <= op_data;
            end
        end
    end

    // Program counter; pops rebuild it high byte then low byte
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            program_counter_q <= 16'h0000;
        end else if (state_q == CFSP_ST_DONE && push_seq_q && len_q != 3'h1) begin
            // Calls and interrupts jump; pops have already rebuilt the return address
            program_counter_q <= tgt_q;
        end else if (state_q == CFSP_ST_FETCH && pop_pc_high()) begin
            program_counter_q[15:8] <= ram_rdata;
        end else if (state_q == CFSP_ST_FETCH && pop_pc_low()) begin
            program_counter_q[7:0] <= ram_rdata;
        end else if (state_q == CFSP_ST_IDLE && pc_load) begin
            program_counter_q <= pc_value;
        end else if (state_q == CFSP_ST_IDLE && pc_inc) begin
            program_counter_q <= program_counter_q + 16'h0001;
        end
    end

    // Pop order mirrors the push: flags, accumulator, index, high, low
    function automatic logic pop_pc_high();
        return (is_irq_q && cnt_q == 3'h3) || (!is_irq_q && len_q == 3'h2 && cnt_q == 3'h0);
    endfunction : pop_pc_high

    function automatic logic pop_pc_low();
        return (is_irq_q && cnt_q == 3'h4) || (!is_irq_q && len_q == 3'h2 && cnt_q == 3'h1);
    endfunction : pop_pc_low

    // Accumulator and first index; the second index is never stacked
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            accumulator_q <= 8'h00;
            index_x_q <= 8'h00;
            index_y_q <= 8'h00;
        end else if (state_q == CFSP_ST_FETCH && is_irq_q && cnt_q == 3'h1) begin
            accumulator_q <= ram_rdata;
        end else if (state_q == CFSP_ST_FETCH && is_irq_q && cnt_q == 3'h2) begin
            index_x_q <= ram_rdata;
        end else if (alu_valid && state_q == CFSP_ST_IDLE) begin
            case (alu_dest)
                2'h0: accumulator_q <= res;
                2'h1: index_x_q <= res;
                2'h2: index_y_q <= res;
                default: accumulator_q <= accumulator_q;
            endcase
        end
    end

    // Condition-code register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= CFSP_CC_RESET;
        end else if (state_q == CFSP_ST_FETCH && (is_irq_q ? cnt_q == 3'h0 : len_q == 3'h1)) begin
            flags_q <= ram_rdata;
        end else if (state_q == CFSP_ST_DONE && is_irq_q && push_seq_q) begin
            {flags_q[CFSP_CC_I1], flags_q[CFSP_CC_I0]} <= vec_priority;
        end else if (state_q == CFSP_ST_IDLE && alu_valid) begin
            if (upd_h) flags_q[CFSP_CC_H] <= half[4];
            flags_q[CFSP_CC_N] <= res[7];
            flags_q[CFSP_CC_Z] <= (res == 8'h00);
            if (upd_c) flags_q[CFSP_CC_C] <= cout;
        end else if (state_q == CFSP_ST_IDLE && op_valid) begin
            case (op_code)
                CFSP_OP_SCF: flags_q[CFSP_CC_C] <= 1'b1;
                CFSP_OP_RCF: flags_q[CFSP_CC_C] <= 1'b0;
                CFSP_OP_BTJ: flags_q[CFSP_CC_C] <= btj_bit;
                CFSP_OP_RIM, CFSP_OP_HALT, CFSP_OP_WFI:
                    {flags_q[CFSP_CC_I1], flags_q[CFSP_CC_I0]} <= CFSP_LVL0;
                CFSP_OP_SIM: {flags_q[CFSP_CC_I1], flags_q[CFSP_CC_I0]} <= CFSP_LVL3;
                default: flags_q <= flags_q;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_masked_q <= 1'b1;
        end else begin
            irq_masked_q <= {flags_q[CFSP_CC_I1], flags_q[CFSP_CC_I0]} == CFSP_LVL3;
        end
    end
endmodule : cfsp_core_regs
`default_nettype wire

// ===== dv/cfsp_core_regs_assertions.sv
// Port-level concurrent checks for the core register set.
`timescale 1ns/10ps
`default_nettype none
module cfsp_core_regs_assertions
    import cfsp_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic alu_valid, // ALU request
    input wire cfsp_alu_t alu_op, // ALU operation
    input wire logic [7:0] alu_a, // First operand
    input wire logic [7:0] alu_b, // Second operand
    input wire logic op_valid, // Special request
    input wire cfsp_op_t op_code, // Special operation
    input wire logic [7:0] op_data, // Stack low byte
    input wire logic [1:0] vec_priority, // Vector priority
    input wire logic [7:0] index_y_q, // Second index
    input wire logic [7:0] condition_code_flags_q, // Flags
    input wire logic [15:0] stack_pointer_q, // Stack pointer
    input wire logic irq_masked_q, // Level 3 in force
    input wire logic busy_q, // Sequence running
    input wire logic done_q // Sequence end
);
    logic op_ok;
    logic alu_ok;
    cfsp_op_t req_op_q;
    logic [7:0] sp_req_q;
    logic [1:0] vec_req_q;

    assign op_ok = op_valid && !busy_q;
    assign alu_ok = alu_valid && !busy_q;

    // Keep the start point of each stack sequence to judge its end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            req_op_q <= CFSP_OP_NONE;
            sp_req_q <= CFSP_SP_LOW_RESET;
            vec_req_q <= CFSP_LVL3;
        end else if (op_ok) begin
            req_op_q <= op_code;
            sp_req_q <= stack_pointer_q[7:0];
            vec_req_q <= vec_priority;
        end
    end

    function automatic logic [7:0] sp_step(input cfsp_op_t op);
        case (op)
            CFSP_OP_IRQ: return 8'hfb;
            CFSP_OP_CALL: return 8'hfe;
            CFSP_OP_PUSHCC: return 8'hff;
            CFSP_OP_POPCC: return 8'h01;
            CFSP_OP_RET: return 8'h02;
            CFSP_OP_INTERRUPT_RETURN_INSTRUCTION: return 8'h05;
            default: return 8'h00;
        endcase
    endfunction : sp_step

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_irq_req;
        op_ok && op_code == CFSP_OP_IRQ;
    endsequence
    sequence s_irq_body;
        busy_q [*5] ##[1:3] done_q;
    endsequence

    property p_irq_timing; s_irq_req |=> s_irq_body; endproperty
    a_irq_timing: assert property (p_irq_timing) else $error("stacking time wrong");
    property p_seq_sp; done_q |-> stack_pointer_q[7:0] == sp_req_q + sp_step(req_op_q); endproperty
    a_seq_sp: assert property (p_seq_sp) else $error("stack pointer step wrong");
    property p_irq_level;
        done_q && req_op_q == CFSP_OP_IRQ |->
            {condition_code_flags_q[5], condition_code_flags_q[3]} == vec_req_q;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("level not loaded");
    property p_y_hold; busy_q |=> $stable(index_y_q); endproperty
    a_y_hold: assert property (p_y_hold) else $error("second index moved");
    property p_sp_page; stack_pointer_q[15:8] == CFSP_SP_HIGH; endproperty
    a_sp_page: assert property (p_sp_page) else $error("stack page moved");
    property p_cc_fixed; condition_code_flags_q[7:6] == 2'h3; endproperty
    a_cc_fixed: assert property (p_cc_fixed) else $error("unused flag bits low");
    property p_masked;
        condition_code_flags_q[5] && condition_code_flags_q[3] |-> ##[0:1] irq_masked_q;
    endproperty
    a_masked: assert property (p_masked) else $error("level 3 not masking");
    property p_rsp; op_ok && op_code == CFSP_OP_RSP |=> stack_pointer_q == CFSP_SP_RESET; endproperty
    a_rsp: assert property (p_rsp) else $error("stack reset wrong");
    property p_lds; op_ok && op_code == CFSP_OP_LDS |=> stack_pointer_q[7:0] == $past(op_data); endproperty
    a_lds: assert property (p_lds) else $error("stack load wrong");
    property p_carry_force;
        op_ok && !alu_valid && (op_code == CFSP_OP_SCF || op_code == CFSP_OP_RCF) |=>
            condition_code_flags_q[0] == ($past(op_code) == CFSP_OP_SCF);
    endproperty
    a_carry_force: assert property (p_carry_force) else $error("carry not forced");
    property p_add_flags;
        alu_ok && alu_op == CFSP_ALU_ADD |=>
            condition_code_flags_q[4] == (5'($past(alu_a[3:0])) + 5'($past(alu_b[3:0])) > 5'h0f) &&
            condition_code_flags_q[0] == (9'($past(alu_a)) + 9'($past(alu_b)) > 9'h0ff);
    endproperty
    a_add_flags: assert property (p_add_flags) else $error("add carries wrong");
    property p_and_flags;
        alu_ok && alu_op == CFSP_ALU_AND |=>
            condition_code_flags_q[2] == ($past(alu_a[7]) && $past(alu_b[7])) &&
            condition_code_flags_q[1] == (($past(alu_a) & $past(alu_b)) == 8'h00);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("sign or zero wrong");
endmodule : cfsp_core_regs_assertions

bind cfsp_core_regs cfsp_core_regs_assertions cfsp_core_regs_assertions_inst (.*);
`default_nettype wire

// ===== dv/cfsp_core_regs_tb.sv
// Self-checking bench for the core register set against a reference model.
`timescale 1ns/10ps
`default_nettype none
module cfsp_core_regs_tb
    import cfsp_pkg::*;
;
    logic mclk, nrst, alu_valid, op_valid, btj_bit, pc_load, pc_inc, busy_q, done_q, irq_masked_q;
    cfsp_alu_t alu_op;
    cfsp_op_t op_code;
    logic [7:0] alu_a, alu_b, op_data, accumulator_q, index_x_q, index_y_q, condition_code_flags_q;
    logic [1:0] alu_dest, vec_priority;
    logic [15:0] op_addr, pc_value, program_counter_q, stack_pointer_q;
    logic [7:0] ra, rb;
    int m_a, m_x, m_y, m_pc, m_cc, m_sp, num_errors, check_count, seed;
    int mem [256];
    cfsp_op_t flag_ops [10] = '{CFSP_OP_RCF, CFSP_OP_SCF, CFSP_OP_BTJ, CFSP_OP_BTJ, CFSP_OP_SIM,
        CFSP_OP_RIM, CFSP_OP_SIM, CFSP_OP_HALT, CFSP_OP_SIM, CFSP_OP_WFI};

    cfsp_core_regs cfsp_core_regs_inst (.*);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_all();
        // Masked output trails the priority pair by one cycle
        @(negedge mclk);
        check(16'(accumulator_q), 16'(m_a));
        check(16'(index_x_q), 16'(m_x));
        check(16'(index_y_q), 16'(m_y));
        check(program_counter_q, 16'(m_pc));
        check(16'(condition_code_flags_q), 16'(m_cc));
        check(stack_pointer_q, {CFSP_SP_HIGH, 8'(m_sp)});
        check(16'(irq_masked_q), 16'(m_cc[5] & m_cc[3]));
    endtask : check_all

    task automatic conclude();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    function automatic void push(input int v);
        mem[m_sp] = v & 255;
        m_sp = (m_sp - 1) & 255;
    endfunction : push

    function automatic int pop();
        m_sp = (m_sp + 1) & 255;
        return mem[m_sp];
    endfunction : pop

    task automatic do_reset();
        nrst = 1'b0;
        m_a = 0;
        m_x = 0;
        m_y = 0;
        m_pc = 0;
        m_cc = CFSP_CC_RESET;
        m_sp = CFSP_SP_LOW_RESET;
        repeat (6) @(negedge mclk);
        nrst = 1'b1;
    endtask : do_reset

    task automatic alu(input cfsp_alu_t op, input logic [7:0] a, input logic [7:0] b,
                       input logic [1:0] d);
        int r;
        int c;
        int ci;
        @(negedge mclk);
        alu_valid = 1'b1;
        alu_op = op;
        alu_a = a;
        alu_b = b;
        alu_dest = d;
        @(negedge mclk);
        alu_valid = 1'b0;
        c = m_cc & 1;
        ci = (op == CFSP_ALU_ADC || op == CFSP_ALU_SBC) ? c : 0;
        case (op)
            CFSP_ALU_ADD, CFSP_ALU_ADC: begin
                r = int'(a) + int'(b) + ci;
                m_cc[4] = ((a & 15) + (b & 15) + ci) > 15;
                c = r > 255;
            end
            CFSP_ALU_SUB, CFSP_ALU_SBC: begin
                r = int'(a) - int'(b) - ci;
                c = r < 0;
            end
            CFSP_ALU_AND: r = a & b;
            CFSP_ALU_OR: r = a | b;
            CFSP_ALU_XOR: r = a ^ b;
            CFSP_ALU_LD: r = b;
            CFSP_ALU_SLL, CFSP_ALU_RLC: begin
                r = (int'(a) << 1) | ((op == CFSP_ALU_RLC) ? c : 0);
                c = a[7];
            end
            default: begin
                r = (int'(a) >> 1) | ((op == CFSP_ALU_RRC) ? c << 7 : 0);
                c = a[0];
            end
        endcase
        r = r & 255;
        m_cc[2] = r[7];
        m_cc[1] = (r == 0);
        m_cc[0] = c[0];
        case (d)
            2'h0: m_a = r;
            2'h1: m_x = r;
            2'h2: m_y = r;
            default: ;
        endcase
    endtask : alu

    task automatic do_op(input cfsp_op_t code, input logic [7:0] data, input logic [15:0] addr,
                         input logic [1:0] vp, input logic bt);
        int n;
        @(negedge mclk);
        op_valid = 1'b1;
        op_code = code;
        op_data = data;
        op_addr = addr;
        vec_priority = vp;
        btj_bit = bt;
        @(negedge mclk);
        op_valid = 1'b0;
        if (code inside {CFSP_OP_PUSHCC, CFSP_OP_POPCC, CFSP_OP_CALL, CFSP_OP_RET,
                         CFSP_OP_IRQ, CFSP_OP_INTERRUPT_RETURN_INSTRUCTION}) begin
            // Poke the second index mid-sequence: a busy block must drop it
            alu_valid = 1'b1;
            alu_op = CFSP_ALU_LD;
            alu_a = 8'h5a;
            alu_b = 8'h5a;
            alu_dest = 2'h2;
            n = 0;
            while (done_q !== 1'b1 && n < 40) begin
                @(negedge mclk);
                alu_valid = 1'b0;
                n++;
            end
            if (n == 40) begin
                num_errors++;
                conclude();
            end
        end
        case (code)
            CFSP_OP_SCF: m_cc[0] = 1;
            CFSP_OP_RCF: m_cc[0] = 0;
            CFSP_OP_BTJ: m_cc[0] = bt;
            CFSP_OP_RIM, CFSP_OP_HALT, CFSP_OP_WFI: m_cc = (m_cc & 8'hd7) | 8'h20;
            CFSP_OP_SIM: m_cc = m_cc | 8'h28;
            CFSP_OP_RSP: m_sp = 255;
            CFSP_OP_LDS: m_sp = data;
            CFSP_OP_PUSHCC: push(m_cc);
            CFSP_OP_POPCC: m_cc = pop() | CFSP_CC_FIXED;
            CFSP_OP_CALL: begin
                push(m_pc);
                push(m_pc >> 8);
                m_pc = addr;
            end
            CFSP_OP_RET: begin
                m_pc = pop() << 8;
                m_pc = m_pc | pop();
            end
            CFSP_OP_IRQ: begin
                push(m_pc);
                push(m_pc >> 8);
                push(m_x);
                push(m_a);
                push(m_cc);
                m_cc = (m_cc & 8'hd7) | (vp[1] << 5) | (vp[0] << 3);
                m_pc = addr;
            end
            default: begin
                m_cc = pop() | CFSP_CC_FIXED;
                m_a = pop();
                m_x = pop();
                m_pc = pop() << 8;
                m_pc = m_pc | pop();
            end
        endcase
    endtask : do_op

    task automatic pc_step(input logic ld, input logic [15:0] v);
        @(negedge mclk);
        pc_load = ld;
        pc_inc = !ld;
        pc_value = v;
        @(negedge mclk);
        pc_load = 1'b0;
        pc_inc = 1'b0;
        m_pc = ld ? v : (m_pc + 1) & 16'hffff;
    endtask : pc_step

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        {alu_valid, op_valid, btj_bit, pc_load, pc_inc} = 5'h00;
        alu_op = CFSP_ALU_ADD;
        op_code = CFSP_OP_NONE;
        {alu_a, alu_b, op_data, alu_dest, vec_priority} = 28'h000_0000;
        {op_addr, pc_value} = 32'h0000_0000;
        num_errors = 0;
        check_count = 0;
        seed = $urandom(32'h5a06_0343);
        do_reset();
        check_all();
        alu(CFSP_ALU_ADD, 8'h0f, 8'h01, 2'h0);
        check_all();
        alu(CFSP_ALU_ADD, 8'hff, 8'h01, 2'h1);
        check_all();
        // LD gets equal operands so either operand reading gives one result
        for (int i = 0; i < 60; i++) begin
            ra = 8'($urandom);
            rb = (i % 12 == 7) ? ra : 8'($urandom);
            alu(cfsp_alu_t'(4'(i % 12)), ra, rb, 2'($urandom));
            check_all();
        end
        foreach (flag_ops[i]) begin
            do_op(flag_ops[i], 8'h00, 16'h0000, 2'h0, i[0]);
            check_all();
        end
        pc_step(1'b1, 16'h12ff);
        pc_step(1'b0, 16'h0000);
        check_all();
        alu(CFSP_ALU_LD, 8'h3c, 8'h3c, 2'h2);
        do_op(CFSP_OP_LDS, 8'h02, 16'h0000, 2'h0, 1'b0);
        check_all();
        do_op(CFSP_OP_IRQ, 8'h00, 16'($urandom) | 16'h0001, 2'($urandom), 1'b0);
        check_all();
        alu(CFSP_ALU_LD, 8'h11, 8'h11, 2'h0);
        alu(CFSP_ALU_LD, 8'h22, 8'h22, 2'h1);
        do_op(CFSP_OP_SIM, 8'h00, 16'h0000, 2'h0, 1'b0);
        do_op(CFSP_OP_INTERRUPT_RETURN_INSTRUCTION, 8'h00, 16'h0000, 2'h0, 1'b0);
        check_all();
        do_op(CFSP_OP_LDS, 8'h00, 16'h0000, 2'h0, 1'b0);
        do_op(CFSP_OP_CALL, 8'h00, 16'h8001, 2'h0, 1'b0);
        check_all();
        do_op(CFSP_OP_RET, 8'h00, 16'h0000, 2'h0, 1'b0);
        check_all();
        do_op(CFSP_OP_PUSHCC, 8'h00, 16'h0000, 2'h0, 1'b0);
        do_op(CFSP_OP_RIM, 8'h00, 16'h0000, 2'h0, 1'b0);
        do_op(CFSP_OP_RCF, 8'h00, 16'h0000, 2'h0, 1'b0);
        do_op(CFSP_OP_POPCC, 8'h00, 16'h0000, 2'h0, 1'b0);
        check_all();
        do_op(CFSP_OP_RSP, 8'h00, 16'h0000, 2'h0, 1'b0);
        check_all();
        do_reset();
        check_all();
        conclude();
    end
endmodule : cfsp_core_regs_tb
`default_nettype wire
